// [inc/qbc_consts.vh]
`ifndef QBC_CONSTS_VH
`define QBC_CONSTS_VH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define QBC_ADDR_RDATA 32'h34000008
`define QBC_ADDR_CMDA 32'h3400000c
`define QBC_ADDR_CMDB 32'h34000010
`define QBC_ADDR_CTRL 32'h34000014
`define QBC_ADDR_STAT 32'h34000018
`define QBC_ADDR_TRIG 32'h3400001c
`define QBC_ADDR_MADR 32'h34000020
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define QBC_RST_CMDA 32'h00000000
`define QBC_RST_CMDB 16'h0000
`define QBC_RST_RDATA 32'h00000000
// writable bits of burst command b; the rest read back as zero
`define QBC_CMDB_MASK 16'hffb0
// ----------------------------------------------------------------------
// burst command a field positions
// ----------------------------------------------------------------------
`define QBC_A_DMY_W 31:30
`define QBC_A_EXT_W 29:28
`define QBC_A_ADR_W 27:26
`define QBC_A_OPC_W 25:24
`define QBC_A_EXT_BYTE 23:16
`define QBC_A_WRAP_OPC 15:8
`define QBC_A_NORM_OPC 7:0
// ----------------------------------------------------------------------
// burst command b field positions
// ----------------------------------------------------------------------
`define QBC_B_FORCE 15
`define QBC_B_IDLE_MIN 14:12
`define QBC_B_WRAP_SIZE 11:10
`define QBC_B_WRAP_LEN 9:8
`define QBC_B_WRAP_EN 7
`define QBC_B_DMY_NUM 5:4
// ----------------------------------------------------------------------
// own control bits and codes
// ----------------------------------------------------------------------
`define QBC_C_NOWAIT 0
`define QBC_C_EXT_EN 1
`define QBC_CODE_RSVD 2'h3
`define QBC_FORCED_DUMMIES 3'h3
// ----------------------------------------------------------------------
// timing: serial clock is pclk divided by this many cycles
// ----------------------------------------------------------------------
`define QBC_PCLK_NS 100
`define QBC_SCK_NS 400
`define QBC_SCK_DIV (`QBC_SCK_NS / `QBC_PCLK_NS)
// last pclk count inside one serial clock: the divider minus one
`define QBC_SCK_LAST 2'h3
`endif

// [sim/qbc_burst_cfg_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "qbc_consts.vh"
module qbc_burst_cfg_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic auto_ack_ff,
	input wire logic qspi_sck_ff,
	input wire logic qspi_cs_n_ff,
	input wire logic [3:0] qspi_io_oe_ff
);
	logic [2:0] idle_ff; // shadow of the select idle field
	logic [5:0] gap_ff; // cycles with select high, saturating
	logic [1:0] opc_w_ff; // shadow of the opcode width field
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// preset gap: the first burst after reset may start at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_ff <= 3'h0;
			gap_ff <= 6'h3f;
			opc_w_ff <= 2'h0;
		end else begin
			if (psel && penable && pready && pwrite &&
				paddr == `QBC_ADDR_CMDB)
				idle_ff <= pwdata[14:12];
			if (psel && penable && pready && pwrite &&
				paddr == `QBC_ADDR_CMDA)
				opc_w_ff <= pwdata[25:24];
			if (!qspi_cs_n_ff)
				gap_ff <= 6'h0;
			else if (gap_ff != 6'h3f)
				gap_ff <= gap_ff + 6'h1;
		end
	end
	idle_gap_a: assert property (
		$fell(qspi_cs_n_ff) |-> gap_ff >= {1'b0, idle_ff, 2'b00})
		else $error("select idle gap too short");
	ready_fast_a: assert property (
		psel && penable && paddr != `QBC_ADDR_TRIG |-> pready)
		else $error("register access delayed");
	ack_pulse_a: assert property (auto_ack_ff |=> !auto_ack_ff)
		else $error("burst ack wider than one cycle");
	ack_idle_a: assert property (auto_ack_ff |-> qspi_cs_n_ff)
		else $error("ack while frame open");
	sck_sel_a: assert property (qspi_sck_ff |-> !qspi_cs_n_ff)
		else $error("serial clock outside frame");
	sck_high_a: assert property (
		$rose(qspi_sck_ff) |-> qspi_sck_ff[*2] ##1 !qspi_sck_ff)
		else $error("serial clock high time wrong");
	open_first_a: assert property (
		$fell(qspi_cs_n_ff) |-> qspi_io_oe_ff[0])
		else $error("opcode not driven at frame start");
	oe_off_a: assert property (
		qspi_cs_n_ff && $past(qspi_cs_n_ff) |-> qspi_io_oe_ff == 4'h0)
		else $error("data lines driven while deselected");
	opc_lines_a: assert property (
		$fell(qspi_cs_n_ff) |-> qspi_io_oe_ff ==
		((opc_w_ff == 2'h2) ? 4'hf : (opc_w_ff == 2'h1) ? 4'h3 : 4'h1))
		else $error("opcode line count wrong");
	cover property ($fell(qspi_cs_n_ff));
	cover property (auto_ack_ff);
	cover property (psel && penable && pready && paddr == `QBC_ADDR_TRIG);
endmodule // qbc_burst_cfg_chk
bind qbc_burst_cfg qbc_burst_cfg_chk u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .auto_ack_ff,
	.qspi_sck_ff, .qspi_cs_n_ff, .qspi_io_oe_ff);
`default_nettype wire

// [sim/qbc_burst_cfg_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "qbc_consts.vh"
module qbc_burst_cfg_tb;
	localparam logic [31:0] WORD = 32'ha5c3_1e7f; // memory data word
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd, auto_rd;
	logic pready, auto_req = 0, auto_wrap = 0, ack, sck, cs_n;
	logic [1:0] auto_len = 0, auto_size = 0;
	logic [3:0] io_o, io_oe, io_i;
	logic [7:0] start = 8'h20, op, ext;
	int failures = 0, n_tests = 0, cyc = 0;
	always #50 pclk = ~pclk;
	qbc_burst_cfg dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr(), .auto_req,
		.auto_addr(24'h001234), .auto_wrap, .auto_len, .auto_size,
		.auto_ack_ff(ack), .auto_rdata_ff(auto_rd), .qspi_sck_ff(sck),
		.qspi_cs_n_ff(cs_n), .qspi_io_o_ff(io_o), .qspi_io_oe_ff(io_oe),
		.qspi_io_i(io_i));
	qbc_mem_model #(.WORD(WORD)) mem (.sck, .cs_n, .io_o, .start, .io_i,
		.op, .ext);
	task automatic chk(input logic [31:0] e, s, input string nm);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic man_rd(input logic [7:0] s);
		start <= s;
		apb(1'b1, `QBC_ADDR_MADR, 32'h0);
		apb(1'b0, `QBC_ADDR_TRIG, 32'h0);
		rd = 32'h1;
		while (rd[0] !== 1'b0) apb(1'b0, `QBC_ADDR_STAT, 32'h0);
		apb(1'b0, `QBC_ADDR_RDATA, 32'h0);
	endtask
	task automatic t_regs;
		apb(1'b0, `QBC_ADDR_RDATA, 32'h0);
		chk(32'h0, rd, "read data reset");
		apb(1'b0, `QBC_ADDR_CMDA, 32'h0);
		chk(32'h0, rd, "cmd a reset");
		apb(1'b0, `QBC_ADDR_CMDB, 32'h0);
		chk(32'h0, rd, "cmd b reset");
		apb(1'b1, `QBC_ADDR_CMDA, 32'hffff_ffff);
		apb(1'b0, `QBC_ADDR_CMDA, 32'h0);
		chk(32'hffff_ffff, rd, "cmd a");
		apb(1'b1, `QBC_ADDR_CMDB, 32'hffff_ffff);
		apb(1'b0, `QBC_ADDR_CMDB, 32'h0);
		chk(32'h0000_ffb0, rd, "cmd b");
		apb(1'b1, `QBC_ADDR_RDATA, 32'hffff_ffff);
		apb(1'b0, `QBC_ADDR_RDATA, 32'h0);
		chk(32'h0, rd, "read data ro");
		apb(1'b0, 32'h3400_0004, 32'h0);
		chk(32'h0, rd, "unmapped");
		$display("test regs done");
	endtask
	// dummy codes 0..3, then force over code 3
	task automatic t_dummy;
		logic [7:0] n;
		apb(1'b1, `QBC_ADDR_CTRL, 32'h1);
		apb(1'b1, `QBC_ADDR_CMDA, 32'h0000_3c0b);
		for (int i = 0; i < 5; i++) begin
			n = (i < 3) ? i : ((i == 3) ? 4 : 3);
			apb(1'b1, `QBC_ADDR_CMDB,
				{16'h0, i == 4, 9'h0, (i == 4) ? 2'h3 : i[1:0], 4'h0});
			man_rd(8'd32 + 8'd8 * n);
			chk(WORD, rd, "manual word");
			chk(32'h0b, {24'h0, op}, "manual opcode");
		end
		$display("test dummy done");
	endtask
	task automatic t_ext;
		apb(1'b1, `QBC_ADDR_CTRL, 32'h3);
		apb(1'b1, `QBC_ADDR_CMDA, 32'h005a_3c0b);
		apb(1'b1, `QBC_ADDR_CMDB, 32'h0);
		man_rd(8'd40);
		chk(WORD, rd, "word after extra");
		chk(32'h5a, {24'h0, ext}, "extra byte");
		apb(1'b1, `QBC_ADDR_CTRL, 32'h1);
		$display("test extra done");
	endtask
	// opcode quad, extra dual, two quad dummy bytes: data at clock 34
	task automatic t_width;
		apb(1'b1, `QBC_ADDR_CTRL, 32'h3);
		apb(1'b1, `QBC_ADDR_CMDA, 32'h9200_000b);
		apb(1'b1, `QBC_ADDR_CMDB, 32'h0000_0020);
		man_rd(8'd34);
		chk(WORD, rd, "word after wide phases");
		$display("test width done");
	endtask
	// waited trigger read: the bus stalls until the word is in
	task automatic t_wait;
		start <= 8'd32;
		apb(1'b1, `QBC_ADDR_CTRL, 32'h0);
		apb(1'b1, `QBC_ADDR_CMDA, 32'h0000_3c0b);
		apb(1'b1, `QBC_ADDR_CMDB, 32'h0);
		apb(1'b0, `QBC_ADDR_TRIG, 32'h0);
		chk(WORD, rd, "waited word");
		chk(32'h0b, {24'h0, op}, "waited opcode");
		apb(1'b0, `QBC_ADDR_STAT, 32'h0);
		chk(32'h0, rd, "idle after waited read");
		$display("test wait done");
	endtask
	// match, wrong length, wrong size, not wrapping, wrap disabled
	task automatic t_wrap;
		start <= 8'd32;
		apb(1'b1, `QBC_ADDR_CMDB, 32'h0000_3980);
		for (int i = 0; i < 5; i++) begin
			if (i == 4) apb(1'b1, `QBC_ADDR_CMDB, 32'h0000_3900);
			auto_wrap <= i != 3;
			auto_len <= (i == 1) ? 2'h2 : 2'h1;
			auto_size <= (i == 2) ? 2'h1 : 2'h2;
			auto_req <= 1'b1;
			@(posedge pclk iff ack === 1'b1);
			auto_req <= 1'b0;
			chk(WORD, auto_rd, "burst word");
			chk((i == 0) ? 32'h3c : 32'h0b, {24'h0, op}, "opcode");
			@(posedge pclk);
		end
		$display("test wrap done");
	endtask
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_dummy();
		t_ext();
		t_width();
		t_wait();
		t_wrap();
		wrap_up();
	end
endmodule // qbc_burst_cfg_tb
`default_nettype wire

// [sim/qbc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module qbc_mem_model #(
	parameter logic [31:0] WORD = 32'h0
) (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_o,
	input wire logic [7:0] start,
	output logic [3:0] io_i,
	output logic [7:0] op,
	output logic [7:0] ext
);
	int n = 0; // serial clock rises in this frame
	logic b; // data bit on the line
	initial io_i = 4'h5;
	always @(posedge cs_n) n = 0;
	// single-line capture of opcode and extra byte
	always @(posedge sck) begin
		if (n < 8) op = {op[6:0], io_o[0]};
		if (n >= 32 && n < 40) ext = {ext[6:0], io_o[0]};
		n++;
	end
	// released lines toggle so a late sample never matches
	always @(negedge sck or posedge cs_n) begin
		if (!cs_n && n >= start && n < start + 32) begin
			b = WORD[31 - (n - start)];
			io_i = {~b, ~b, b, ~b};
		end else
			io_i = ~io_i;
	end
endmodule // qbc_mem_model
`default_nettype wire

// [verilog/qbc_burst_cfg.v]
`timescale 1ns/1ps
`default_nettype none
`include "qbc_consts.vh"

module qbc_burst_cfg (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output wire pslverr,
	input wire auto_req,
	input wire [23:0] auto_addr,
	input wire auto_wrap,
	input wire [1:0] auto_len,
	input wire [1:0] auto_size,
	output reg auto_ack_ff,
	output reg [31:0] auto_rdata_ff,
	output reg qspi_sck_ff,
	output reg qspi_cs_n_ff,
	output reg [3:0] qspi_io_o_ff,
	output reg [3:0] qspi_io_oe_ff,
	input wire [3:0] qspi_io_i
);

// ----------------------------------------------------------------------
// engine states, one-hot, and helper functions
// ----------------------------------------------------------------------
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_OPC = 6'h02;
localparam [5:0] ST_ADR = 6'h04;
localparam [5:0] ST_EXT = 6'h08;
localparam [5:0] ST_DMY = 6'h10;
localparam [5:0] ST_DAT = 6'h20;
localparam [1:0] SCK_LAST = `QBC_SCK_LAST;
// line count per clock for a width code; reserved falls back to single
function [2:0] lines_of;
	input [1:0] code;
	begin
		case (code)
			2'h1: lines_of = 3'h2;
			2'h2: lines_of = 3'h4;
			default: lines_of = 3'h1;
		endcase
	end
endfunction
// pin pattern for the top bits of the shifter
function [3:0] drive_of;
	input [3:0] top;
	input [2:0] w;
	begin
		case (w)
			3'h2: drive_of = {2'h0, top[3:2]};
			3'h4: drive_of = top;
			default: drive_of = {3'h0, top[3]};
		endcase
	end
endfunction
// enable pattern for a phase width
function [3:0] oe_of;
	input [2:0] w;
	begin
		case (w)
			3'h2: oe_of = 4'h3;
			3'h4: oe_of = 4'hf;
			default: oe_of = 4'h1;
		endcase
	end
endfunction

// ----------------------------------------------------------------------
// registers seen by software
// ----------------------------------------------------------------------
reg [31:0] cmd_a_ff; // burst command a
reg [15:0] cmd_b_ff; // burst command b, upper half reserved
reg [1:0] ctrl_ff; // no-wait select, extra byte enable
reg [23:0] man_addr_ff; // manual read address
reg [31:0] rdata_ff; // received_word
reg busy_ff; // transfer_busy_flag
reg man_pend_ff; // manual read owns the engine
reg man_done_ff; // one-cycle pulse: manual read finished
reg man_wait_ff; // bus held waiting for the manual word
wire no_wait_state_select = ctrl_ff[`QBC_C_NOWAIT];
wire extra_byte_enable = ctrl_ff[`QBC_C_EXT_EN];
wire acc = psel & penable;
wire wr_acc = acc & pwrite;
wire trig_rd = acc & ~pwrite & (paddr == `QBC_ADDR_TRIG);
// derived burst settings
wire [2:0] w_opc = lines_of(cmd_a_ff[`QBC_A_OPC_W]);
wire [2:0] w_adr = lines_of(cmd_a_ff[`QBC_A_ADR_W]);
wire [2:0] w_ext = lines_of(cmd_a_ff[`QBC_A_EXT_W]);
wire [2:0] w_dmy = lines_of(cmd_a_ff[`QBC_A_DMY_W]);
reg [2:0] dmy_bytes;
// dummy byte count, force wins over the count field
always @* begin
	case (cmd_b_ff[`QBC_B_DMY_NUM])
		2'h1: dmy_bytes = 3'h1;
		2'h2: dmy_bytes = 3'h2;
		2'h3: dmy_bytes = 3'h4;
		default: dmy_bytes = 3'h0;
	endcase
	if (cmd_b_ff[`QBC_B_FORCE])
		dmy_bytes = `QBC_FORCED_DUMMIES;
end
// wrap opcode only on an exact shape match; reserved codes never match
wire wrap_hit = auto_wrap & cmd_b_ff[`QBC_B_WRAP_EN] &
	(auto_len == cmd_b_ff[`QBC_B_WRAP_LEN]) &
	(auto_size == cmd_b_ff[`QBC_B_WRAP_SIZE]) &
	(auto_len != `QBC_CODE_RSVD) & (auto_size != `QBC_CODE_RSVD);
wire [7:0] opcode = wrap_hit ? cmd_a_ff[`QBC_A_WRAP_OPC] :
	cmd_a_ff[`QBC_A_NORM_OPC];
// ----------------------------------------------------------------------
// serial engine state
// ----------------------------------------------------------------------
reg [5:0] st_ff; // phase
reg [1:0] div_ff; // pclk count inside one serial clock
reg [5:0] bits_ff; // bits left in the phase
reg [2:0] wid_ff; // lines of the phase
reg [31:0] sh_ff; // shifter, msb first
reg [23:0] adr_ff; // latched address
reg src_man_ff; // burst serves the manual read
reg [4:0] gap_ff; // pclk since chip select rose, saturating
reg [3:0] in_s1_ff; // synchroniser first stage
reg [3:0] in_s2_ff; // synchroniser second stage
wire gap_ok = (gap_ff >= {cmd_b_ff[`QBC_B_IDLE_MIN], 2'h0});
wire bit_end = (div_ff == SCK_LAST);
wire ph_end = bit_end & (bits_ff == {3'h0, wid_ff});
wire [31:0] shifted = sh_ff << wid_ff;
wire [31:0] rx_next = (wid_ff == 3'h4) ? {sh_ff[27:0], in_s2_ff} :
	(wid_ff == 3'h2) ? {sh_ff[29:0], in_s2_ff[1:0]} :
	{sh_ff[30:0], in_s2_ff[1]};
wire man_go = man_pend_ff & ~man_done_ff & ~busy_ff; // done blocks restart
wire go_ok = (st_ff == ST_IDLE) & gap_ok & ~auto_ack_ff;

// pin input synchroniser
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		in_s1_ff <= 4'h0;
		in_s2_ff <= 4'h0;
	end else begin
		in_s1_ff <= qspi_io_i;
		in_s2_ff <= in_s1_ff;
	end
end

// ----------------------------------------------------------------------
// burst sequencer: opcode, address, extra, dummy, data
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		st_ff <= ST_IDLE;
		div_ff <= 2'h0;
		bits_ff <= 6'h0;
		wid_ff <= 3'h1;
		sh_ff <= 32'h0;
		adr_ff <= 24'h0;
		src_man_ff <= 1'b0;
		gap_ff <= 5'h1f;
		busy_ff <= 1'b0;
		man_done_ff <= 1'b0;
		auto_ack_ff <= 1'b0;
		auto_rdata_ff <= 32'h0;
		rdata_ff <= `QBC_RST_RDATA;
		qspi_sck_ff <= 1'b0;
		qspi_cs_n_ff <= 1'b1;
		qspi_io_o_ff <= 4'h0;
		qspi_io_oe_ff <= 4'h0;
	end else begin
		man_done_ff <= 1'b0;
		auto_ack_ff <= 1'b0;
		case (st_ff)
			ST_IDLE: begin
				// gap counts only while chip select is high
				if (gap_ff != 5'h1f)
					gap_ff <= gap_ff + 5'h1;
				// manual read first, then a waiting bus burst
				if (go_ok & (man_go | auto_req)) begin
					st_ff <= ST_OPC;
					src_man_ff <= man_go;
					busy_ff <= 1'b1;
					adr_ff <= man_go ? man_addr_ff : auto_addr;
					sh_ff <= {(man_go ? cmd_a_ff[`QBC_A_NORM_OPC] :
						opcode), 24'h0};
					bits_ff <= 6'h8;
					wid_ff <= w_opc;
					div_ff <= 2'h0;
					qspi_cs_n_ff <= 1'b0;
					qspi_io_o_ff <= drive_of(man_go ?
						cmd_a_ff[7:4] : opcode[7:4], w_opc);
					qspi_io_oe_ff <= oe_of(w_opc);
				end
			end
			default: begin
				div_ff <= bit_end ? 2'h0 : div_ff + 2'h1;
				// mode 0 clock: low half then high half
				if (div_ff == 2'h1)
					qspi_sck_ff <= 1'b1;
				if (bit_end)
					qspi_sck_ff <= 1'b0;
				if (bit_end & ~ph_end) begin
					bits_ff <= bits_ff - {3'h0, wid_ff};
					if (st_ff == ST_DAT) begin
						sh_ff <= rx_next;
					end else begin
						sh_ff <= shifted;
						qspi_io_o_ff <= drive_of(shifted[31:28], wid_ff);
					end
				end
				if (ph_end) begin
					case (st_ff)
						ST_OPC: begin
							st_ff <= ST_ADR;
							sh_ff <= {adr_ff, 8'h0};
							bits_ff <= 6'd24;
							wid_ff <= w_adr;
							qspi_io_o_ff <= drive_of(adr_ff[23:20], w_adr);
							qspi_io_oe_ff <= oe_of(w_adr);
						end
						ST_ADR, ST_EXT, ST_DMY: begin
							if ((st_ff == ST_ADR) & extra_byte_enable) begin
								st_ff <= ST_EXT;
								sh_ff <= {cmd_a_ff[`QBC_A_EXT_BYTE], 24'h0};
								bits_ff <= 6'h8;
								wid_ff <= w_ext;
								qspi_io_o_ff <= drive_of(cmd_a_ff[23:20], w_ext);
								qspi_io_oe_ff <= oe_of(w_ext);
							end else if ((st_ff != ST_DMY) &
								(dmy_bytes != 3'h0)) begin
								st_ff <= ST_DMY;
								sh_ff <= 32'h0;
								bits_ff <= {dmy_bytes, 3'h0};
								wid_ff <= w_dmy;
								qspi_io_o_ff <= 4'h0;
								qspi_io_oe_ff <= oe_of(w_dmy);
							end else begin
								st_ff <= ST_DAT;
								sh_ff <= 32'h0;
								bits_ff <= 6'd32;
								wid_ff <= w_adr;
								qspi_io_oe_ff <= 4'h0;
							end
						end
						default: begin
							// last data beat: close the burst
							st_ff <= ST_IDLE;
							qspi_cs_n_ff <= 1'b1;
							gap_ff <= 5'h0;
							busy_ff <= 1'b0;
							if (src_man_ff) begin
								rdata_ff <= rx_next;
								man_done_ff <= 1'b1;
							end else begin
								auto_rdata_ff <= rx_next;
								auto_ack_ff <= 1'b1;
							end
							src_man_ff <= 1'b0;
						end
					endcase
				end
			end
		endcase
	end
end

// register writes and manual read request
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cmd_a_ff <= `QBC_RST_CMDA;
		cmd_b_ff <= `QBC_RST_CMDB;
		ctrl_ff <= 2'h0;
		man_addr_ff <= 24'h0;
		man_pend_ff <= 1'b0;
		man_wait_ff <= 1'b0;
	end else begin
		if (wr_acc & (paddr == `QBC_ADDR_CMDA))
			cmd_a_ff <= pwdata;
		if (wr_acc & (paddr == `QBC_ADDR_CMDB))
			cmd_b_ff <= pwdata[15:0] & `QBC_CMDB_MASK;
		if (wr_acc & (paddr == `QBC_ADDR_CTRL))
			ctrl_ff <= pwdata[1:0];
		if (wr_acc & (paddr == `QBC_ADDR_MADR))
			man_addr_ff <= pwdata[23:0];
		// a trigger read while busy is answered but starts nothing
		if (trig_rd & ~man_wait_ff & ~man_pend_ff & ~busy_ff) begin
			man_pend_ff <= 1'b1;
			man_wait_ff <= ~no_wait_state_select;
		end
		if (man_done_ff) begin
			man_pend_ff <= 1'b0;
			man_wait_ff <= 1'b0;
		end
	end
end

assign pslverr = 1'b0; // no error responses
// apb read mux and ready; trigger reads may stall
always @* begin
	pready = 1'b1;
	case (paddr)
		`QBC_ADDR_RDATA: prdata = rdata_ff;
		`QBC_ADDR_CMDA: prdata = cmd_a_ff;
		`QBC_ADDR_CMDB: prdata = {16'h0, cmd_b_ff};
		`QBC_ADDR_CTRL: prdata = {30'h0, ctrl_ff};
		`QBC_ADDR_STAT: prdata = {31'h0, busy_ff | man_pend_ff};
		`QBC_ADDR_MADR: prdata = {8'h0, man_addr_ff};
		`QBC_ADDR_TRIG: begin
			// waited mode stalls the bus until the word is in
			prdata = rdata_ff;
			if (man_wait_ff | (trig_rd & ~no_wait_state_select &
				~man_pend_ff & ~busy_ff))
				pready = man_done_ff;
		end
		default: prdata = 32'h0;
	endcase
end

endmodule // qbc_burst_cfg
`default_nettype wire
